// [src/swild_top.sv]
// standby wake interrupt level detector, top level
// assumes settings held by clock generator logic, pins are asynchronous
// Notes on behaviour
// - direct peripheral lines signal requests high
// - active level held per source in clock generator logic, taken in as an input
// - peripheral wake sources detected on edges
// - pin sources: high, low, rise, fall
// - wake needs enable and programmed level
// - detected request forwarded as high level
// - timer7 match, cmp1 and overflow share line 96
// - dma unit a error 126, unit b 127
// - clear drops latched request before enabling
`timescale 1ns/1ns
module swild_top
   import swild_pkg::*;
#(
   parameter int NUM_PERIPH = 2, // peripheral wake sources
   parameter int NUM_PIN    = 2  // external pin wake sources
) (
   // clock and reset
   input  wire logic                            core_clk_in,
   input  wire logic                            rstn_in,
   // per-source settings, peripherals then pins
   input  wire logic [NUM_PERIPH+NUM_PIN-1:0]   wake_irq_enable_in,
   input  wire logic [2*(NUM_PERIPH+NUM_PIN)-1:0] wake_active_level_in,
   input  wire logic [NUM_PERIPH+NUM_PIN-1:0]   wake_request_clear_in,
   // wake sources
   input  wire logic [NUM_PERIPH-1:0]           periph_wake_in,
   input  wire logic [NUM_PIN-1:0]              pin_wake_in,
   input  wire logic                            rtc_wake_irq_in,
   input  wire logic                            rtc_enable_in,
   input  wire logic [1:0]                      wake_mode_ctrl_d_in,
   input  wire logic                            rtc_clear_in,
   // direct peripheral lines
   input  wire logic                            timer7_match_in,
   input  wire logic                            timer7_cmp1_in,
   input  wire logic                            timer7_ovf_in,
   input  wire logic                            dma_unit_a_error_in,
   input  wire logic                            dma_unit_b_error_in,
   // toward cpu controller
   output logic [NUM_PERIPH+NUM_PIN-1:0]        wake_req_out,
   output logic                                 rtc_wake_irq_out,
   output logic [SWILD_IRQ_COUNT-1:0]           cpu_irq_out
);
   import swild_pkg::*;
   localparam int NSRC = NUM_PERIPH + NUM_PIN;
   initial begin
      if (NUM_PERIPH < 1 || NUM_PIN < 1) begin
         $error("need at least one peripheral and one pin source");
      end
   end
   // ----------------------------------------------------------------------
   // state: pin synchronisers and registered direct lines
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [NUM_PIN-1:0] s1;   // first sync stage, read by s2 only
      logic [NUM_PIN-1:0] s2;   // second stage
      logic [NUM_PIN-1:0] s3;   // third stage
      logic [NUM_PIN-1:0] pin;  // agreed pin level
      logic               t7;   // timer7 shared line
      logic               dma_a; // dma unit a error line
      logic               dma_b; // dma unit b error line
   } swild_top_st_t;
   swild_top_st_t st;       // registered
   swild_top_st_t next_st;  // next
   logic [NSRC-1:0] src;    // peripheral and pin wake sources, synchronous
   // a pin change counts only once stages two and three agree
   always_comb begin
      next_st     = st;
      next_st.s1  = pin_wake_in;
      next_st.s2  = st.s1;
      next_st.s3  = st.s2;
      for (int i = 0; i < NUM_PIN; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.pin[i] = st.s3[i];
         end
      end
      next_st.t7    = timer7_match_in | timer7_cmp1_in
                    | timer7_ovf_in;
      next_st.dma_a = dma_unit_a_error_in;
      next_st.dma_b = dma_unit_b_error_in;
   end
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign src = {st.pin, periph_wake_in};
   // ----------------------------------------------------------------------
   // one detector per source, level held per source outside this block
   // ----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NSRC; g++) begin : g_chan
         swild_chan #(.IS_PIN(g >= NUM_PERIPH)) u_chan (
            .core_clk_in          (core_clk_in),
            .rstn_in              (rstn_in),
            .wake_irq_enable_in   (wake_irq_enable_in[g]),
            .wake_active_level_in (wake_active_level_in[2*g+:2]),
            .clear_in             (wake_request_clear_in[g]),
            .src_in               (src[g]),
            .req_out              (wake_req_out[g])
         );
      end
   endgenerate
   // rtc source; software is expected to pick falling edge
   swild_chan #(.IS_PIN(1'b0)) u_rtc (
      .core_clk_in          (core_clk_in),
      .rstn_in              (rstn_in),
      .wake_irq_enable_in   (rtc_enable_in),
      .wake_active_level_in (wake_mode_ctrl_d_in),
      .clear_in             (rtc_clear_in),
      .src_in               (rtc_wake_irq_in),
      .req_out              (rtc_wake_irq_out)
   );
   // ----------------------------------------------------------------------
   // cpu vector: all high-active, cpu sees high as request
   // ----------------------------------------------------------------------
   always_comb begin
      cpu_irq_out                   = '0;
      cpu_irq_out[SWILD_IRQ_TIMER7] = st.t7;
      cpu_irq_out[SWILD_IRQ_RTC]    = rtc_wake_irq_out;
      cpu_irq_out[SWILD_IRQ_DMA_A]  = st.dma_a;
      cpu_irq_out[SWILD_IRQ_DMA_B]  = st.dma_b;
   end
   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   sequence s_t7_event;
      timer7_match_in || timer7_cmp1_in || timer7_ovf_in;
   endsequence
   chk_t7_shared: assert property (@(posedge core_clk_in) disable iff
      (!rstn_in) s_t7_event |=> cpu_irq_out[SWILD_IRQ_TIMER7])
      else $error("timer7 event not on shared line");
   chk_dma_split: assert property (@(posedge core_clk_in) disable iff
      (!rstn_in) (dma_unit_a_error_in && !dma_unit_b_error_in) |=>
      (cpu_irq_out[SWILD_IRQ_DMA_A] && !cpu_irq_out[SWILD_IRQ_DMA_B]))
      else $error("dma error lines mixed");
   // an enabled falling rtc edge must show on the cpu line one cycle on
   chk_rtc_line: assert property (@(posedge core_clk_in) disable iff
      (!rstn_in) (rtc_enable_in && wake_mode_ctrl_d_in == SWILD_LVL_FALL
      && $fell(rtc_wake_irq_in)) |=> cpu_irq_out[SWILD_IRQ_RTC])
      else $error("rtc request not forwarded");
   // with no timer7 event the shared line must fall back low
   chk_t7_quiet: assert property (@(posedge core_clk_in) disable iff
      (!rstn_in) !s_t7_event |=> !cpu_irq_out[SWILD_IRQ_TIMER7])
      else $error("timer7 line high without event");
   // unit b error alone must never show on the unit a line
   chk_dma_b_split: assert property (@(posedge core_clk_in) disable iff
      (!rstn_in) (dma_unit_b_error_in && !dma_unit_a_error_in) |=>
      (cpu_irq_out[SWILD_IRQ_DMA_B] && !cpu_irq_out[SWILD_IRQ_DMA_A]))
      else $error("dma unit b error on wrong line");
   // reset wipes every pending request; no disable here on purpose
   chk_reset_quiet: assert property (@(posedge core_clk_in)
      !rstn_in |=> (wake_req_out == '0 && !rtc_wake_irq_out &&
      cpu_irq_out == '0))
      else $error("request left standing after reset");
   // ----------------------------------------------------------------------
   // checks: pin path, one set per pin
   // ----------------------------------------------------------------------
   // a pin level reaches a detector only after stages two and three agree,
   // so a one-cycle glitch in stage one can never raise a request
   for (g = 0; g < NUM_PIN; g++) begin : g_pin_chk
      // stages two and three disagree: the input is still moving
      sequence s_pin_moving;
         st.s2[g] != st.s3[g];
      endsequence
      // stages agree: the agreed level follows stage three
      sequence s_pin_settled;
         st.s2[g] == st.s3[g];
      endsequence
      // an enabled high-level pin that stands high now
      sequence s_pin_high_armed;
         wake_irq_enable_in[NUM_PERIPH+g] &&
         wake_active_level_in[2*(NUM_PERIPH+g)+:2] == SWILD_LVL_HIGH &&
         st.pin[g];
      endsequence
      // an enabled low-level pin that stands low now
      sequence s_pin_low_armed;
         wake_irq_enable_in[NUM_PERIPH+g] &&
         wake_active_level_in[2*(NUM_PERIPH+g)+:2] == SWILD_LVL_LOW &&
         !st.pin[g];
      endsequence
      // no move of the agreed level while the stages disagree
      chk_pin_hold: assert property (@(posedge core_clk_in) disable iff
         (!rstn_in) s_pin_moving |=> $stable(st.pin[g]))
         else $error("pin level moved before stages agreed");
      // once they agree, the agreed level takes stage three
      chk_pin_follow: assert property (@(posedge core_clk_in) disable iff
         (!rstn_in) s_pin_settled |=> st.pin[g] == $past(st.s3[g]))
         else $error("pin level did not follow settled input");
      // level modes latch while the level is present
      chk_pin_high: assert property (@(posedge core_clk_in) disable iff
         (!rstn_in) s_pin_high_armed |=> wake_req_out[NUM_PERIPH+g])
         else $error("high level on pin not latched");
      chk_pin_low: assert property (@(posedge core_clk_in) disable iff
         (!rstn_in) s_pin_low_armed |=> wake_req_out[NUM_PERIPH+g])
         else $error("low level on pin not latched");
   end
   // limitation: level modes keep re-setting the latch, so software must
   // remove the level at the pin before a clear can take effect
endmodule : swild_top

// [src/swild_pkg.sv]
// package for the standby wake interrupt level detector
// assumes a single 10 MHz system clock and synchronous active-low reset
package swild_pkg;
   // ----------------------------------------------------------------------
   // active level field encodings
   // ----------------------------------------------------------------------
   localparam logic [1:0] SWILD_LVL_LOW  = 2'h0; // low level (pins only)
   localparam logic [1:0] SWILD_LVL_HIGH = 2'h1; // high level (pins only)
   localparam logic [1:0] SWILD_LVL_FALL = 2'h2; // falling edge
   localparam logic [1:0] SWILD_LVL_RISE = 2'h3; // rising edge
   localparam logic [1:0] SWILD_LVL_RST  = 2'h2; // reset value, falling edge
   // ----------------------------------------------------------------------
   // interrupt numbers of the direct lines and of the detected rtc request
   // ----------------------------------------------------------------------
   localparam int SWILD_IRQ_TIMER7 = 96;
   localparam int SWILD_IRQ_RTC    = 99;
   localparam int SWILD_IRQ_DMA_A  = 126;
   localparam int SWILD_IRQ_DMA_B  = 127;
   localparam int SWILD_IRQ_COUNT  = 128;
   // ----------------------------------------------------------------------
   // synchroniser depth for pin inputs
   // ----------------------------------------------------------------------
   localparam int SWILD_SYNC_STAGES = 3;
endpackage : swild_pkg

// [src/swild_chan.sv]
// one wake source: level/edge detector with a sticky pending latch
// assumes the input is already synchronous to core_clk_in
`timescale 1ns/1ns
module swild_chan
   import swild_pkg::*;
#(
   parameter bit IS_PIN = 1'b0 // pin sources allow level modes
) (
   // clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       rstn_in,
   // settings
   input  wire logic       wake_irq_enable_in,
   input  wire logic [1:0] wake_active_level_in,
   input  wire logic       clear_in,
   // source and result
   input  wire logic       src_in,
   output logic            req_out
);
   import swild_pkg::*;
   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic prev;    // source one cycle ago
      logic pending; // latched request
   } swild_chan_st_t;
   swild_chan_st_t st;      // registered state
   swild_chan_st_t next_st; // next state
   logic           hit;     // detection this cycle
   // detection per active level; peripherals only use edges
   always_comb begin
      hit = 1'b0;
      case (wake_active_level_in)
         SWILD_LVL_RISE: hit = src_in & ~st.prev;
         SWILD_LVL_FALL: hit = ~src_in & st.prev;
         SWILD_LVL_HIGH: hit = IS_PIN & src_in;
         SWILD_LVL_LOW:  hit = IS_PIN & ~src_in;
         default:        hit = 1'b0;
      endcase
   end
   // next state: set beats clear so no event is lost
   always_comb begin
      next_st      = st;
      next_st.prev = src_in;
      if (clear_in) begin
         next_st.pending = 1'b0;
      end
      if (wake_irq_enable_in && hit) begin
         next_st.pending = 1'b1;
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   // high level toward the cpu controller
   assign req_out = st.pending;
   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   chk_pend_hold: assert property (@(posedge core_clk_in) disable iff
      (!rstn_in) (req_out && !clear_in) |=> req_out)
      else $error("pending dropped without clear");
   chk_disabled_quiet: assert property (@(posedge core_clk_in) disable iff
      (!rstn_in) (!req_out && !wake_irq_enable_in) |=> !req_out)
      else $error("request set while disabled");
   chk_clear_drop: assert property (@(posedge core_clk_in) disable iff
      (!rstn_in) (clear_in && !(wake_irq_enable_in && hit)) |=> !req_out)
      else $error("clear did not drop request");
   chk_rise_set: assert property (@(posedge core_clk_in) disable iff
      (!rstn_in) (wake_irq_enable_in && wake_active_level_in ==
      SWILD_LVL_RISE && $rose(src_in)) |=> req_out)
      else $error("rising edge missed");
   chk_fall_set: assert property (@(posedge core_clk_in) disable iff
      (!rstn_in) (wake_irq_enable_in && wake_active_level_in ==
      SWILD_LVL_FALL && $fell(src_in)) |=> req_out)
      else $error("falling edge missed");
endmodule : swild_chan

// [testbench/swild_cpu_model.sv]
// cpu side model: interrupt inputs of the nested controller
// assumes the request lines are synchronous to core_clk_in
`timescale 1ns/1ns
module swild_cpu_model (
   // clock and reset
   input  wire logic                                 core_clk_in,
   input  wire logic                                 rstn_in,
   // request lines from the detector
   input  wire logic [swild_pkg::SWILD_IRQ_COUNT-1:0] irq_in,
   // requests taken so far, sticky
   output logic      [swild_pkg::SWILD_IRQ_COUNT-1:0] taken_out
);
   import swild_pkg::*;
   // a high level is taken as a request; no edge is needed
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in)
         taken_out <= '0;
      else
         taken_out <= taken_out | irq_in;
   end
endmodule : swild_cpu_model

// [testbench/testbench.sv]
// testbench for the standby wake interrupt level detector
// assumes default parameters: sources 0..1 peripherals, 2..3 pins
`timescale 1ns/1ns
module testbench;
   import swild_pkg::*;
   // ---------------------------------------------------------------
   // stimulus and observed signals
   // ---------------------------------------------------------------
   logic         clk = 0, rstn = 0;        // clock, reset
   logic [3:0]   en = '0, clr = '0;        // per-source settings
   logic [7:0]   lvl = '0;                 // active levels
   logic [1:0]   per = '0, pin = '0;       // wake sources
   logic         rtc = 0, rtc_en = 0;      // rtc source
   logic         rtc_clr = 0;              // rtc clear
   logic [1:0]   rtc_mode = SWILD_LVL_RISE;// rtc active level
   logic [2:0]   tmr = '0;                 // overflow, cmp1, match
   logic [1:0]   dma = '0;                 // unit b, unit a
   logic [3:0]   wreq;                     // pending per source
   logic         rtc_out;                  // rtc pending
   logic [127:0] cpu, taken;               // cpu lines, model view
   int           n_errors = 0, n_compared = 0, cycles = 0;
   // ---------------------------------------------------------------
   // clock, device, partner, hang guard
   // ---------------------------------------------------------------
   initial forever #50 clk = ~clk;
   swild_top DUT (.core_clk_in(clk), .rstn_in(rstn),
      .wake_irq_enable_in(en), .wake_active_level_in(lvl),
      .wake_request_clear_in(clr), .periph_wake_in(per),
      .pin_wake_in(pin), .rtc_wake_irq_in(rtc), .rtc_enable_in(rtc_en),
      .wake_mode_ctrl_d_in(rtc_mode), .rtc_clear_in(rtc_clr),
      .timer7_match_in(tmr[0]), .timer7_cmp1_in(tmr[1]),
      .timer7_ovf_in(tmr[2]), .dma_unit_a_error_in(dma[0]),
      .dma_unit_b_error_in(dma[1]), .wake_req_out(wreq),
      .rtc_wake_irq_out(rtc_out), .cpu_irq_out(cpu));
   swild_cpu_model cpu_side (.core_clk_in(clk), .rstn_in(rstn),
      .irq_in(cpu), .taken_out(taken));
   // a hang counts as a mismatch; tests need about 110 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         summarize();
      end
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic tick(input int n = 1); // inputs change 1 ns late
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic chk(input logic seen, input logic exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %b expected %b", $time, seen, exp);
      end
   endtask : chk
   // probe: 0..3 pending, 4 rtc pending, else a cpu line
   function automatic logic probe(input int s);
      return s < 4 ? wreq[s] : (s == 4 ? rtc_out : cpu[s]);
   endfunction : probe
   // bounded wait, then one compare; n = 0 compares at once
   task automatic wait_for(input int s, input logic e, input int n);
      for (int i = 0; i < n && probe(s) !== e; i++)
         tick();
      chk(probe(s), e);
   endtask : wait_for
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_periph();            // edges, latch, clear
      lvl[3:0] = {SWILD_LVL_FALL, SWILD_LVL_RISE};
      clr[1:0] = 2'h3;
      tick();
      clr[1:0] = 2'h0;
      en[0]    = 1;
      per      = 2'h3;                   // rise on 0, no fall on 1
      tick();
      wait_for(0, 1, 0);
      per = 2'h0;                        // fall on 1, but disabled
      tick(3);
      wait_for(0, 1, 0);
      wait_for(1, 0, 0);
      en[1] = 1;
      per[1] = 1;
      tick();
      wait_for(1, 0, 0);
      per[1] = 0;
      tick();
      wait_for(1, 1, 0);
      clr[0] = 1;
      tick();
      clr[0] = 0;
      wait_for(0, 0, 0);
      wait_for(1, 1, 0);
      $display("test periph done");
   endtask : t_periph
   task automatic t_pins();              // all four pin modes
      logic [1:0] m;
      logic       act;
      for (int i = 0; i < 4; i++) begin
         m        = 2'(i);
         act      = (m == SWILD_LVL_HIGH) || (m == SWILD_LVL_RISE);
         en[2]    = 0;
         lvl[5:4] = m;
         pin[0]   = !act;                // idle level
         tick(8);                        // let the synchroniser settle
         clr[2] = 1;
         tick();
         clr[2] = 0;
         en[2]  = 1;
         tick(6);
         wait_for(2, 0, 0);
         pin[0] = act;
         wait_for(2, 1, 10);
      end
      en[2] = 0;
      $display("test pins done");
   endtask : t_pins
   task automatic t_rtc();               // rtc set for falling edge
      rtc_mode = SWILD_LVL_FALL;
      rtc_clr  = 1;
      tick();
      rtc_clr = 0;
      rtc_en  = 1;
      rtc     = 1;
      tick(2);
      wait_for(4, 0, 0);
      rtc = 0;
      tick();
      wait_for(4, 1, 0);
      wait_for(99, 1, 3);
      $display("test rtc done");
   endtask : t_rtc
   task automatic t_direct();            // shared timer line, dma
      for (int i = 0; i < 3; i++) begin
         tmr = 3'(1 << i);
         wait_for(96, 1, 3);
         tmr = 3'h0;
         wait_for(96, 0, 3);
      end
      for (int i = 0; i < 2; i++) begin
         dma = 2'(1 << i);
         wait_for(126 + i, 1, 3);
         chk(cpu[127 - i], 0);
         dma = 2'h0;
         wait_for(126 + i, 0, 3);
      end
      tick();
      chk(taken[127], 1);
      $display("test direct done");
   endtask : t_direct
   // ---------------------------------------------------------------
   // closing report and main sequence
   // ---------------------------------------------------------------
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   initial begin
      tick(5);
      rstn = 1;
      t_periph();
      t_pins();
      t_rtc();
      t_direct();
      summarize();
   end
endmodule : testbench
